// ### shared/lfd_pkg.sv
/*
  constants, state codes and threshold math for the line frequency discriminator.
  assumes a 100 MHz core clock and a 25 MHz peripheral clock reference.
*/
package lfd_pkg;

  // clock figures
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned PCLK_HZ  = 25_000_000;
  localparam int unsigned PCLK_DIV = 32;
  localparam int unsigned CLK_NS   = 1_000_000_000 / CLK_HZ;
  // one interval tick in ns (32 peripheral clocks) and in core cycles
  localparam int unsigned TICK_NS  = 1_000_000_000 / PCLK_HZ * PCLK_DIV;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;

  // interval counter width and its ceiling
  localparam int unsigned CNT_W   = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // ticks per period minus one, rounded to nearest
  function automatic logic [15:0] lfd_thr(input int unsigned hz);
    int unsigned twice;
    twice = (2 * PCLK_HZ) / (hz * PCLK_DIV);
    return 16'((twice + 1) / 2 - 1);
  endfunction

  // boundaries: 17360, 14204, 12018 ticks
  localparam logic [15:0] THR_45 = lfd_thr(45);
  localparam logic [15:0] THR_55 = lfd_thr(55);
  localparam logic [15:0] THR_65 = lfd_thr(65);

  // classification codes
  localparam logic [1:0] RESULT_ERROR_CODE = 2'h0;
  localparam logic [1:0] RESULT_FIFTY_CODE = 2'h1;
  localparam logic [1:0] RESULT_SIXTY_CODE = 2'h2;

  // equal classifications needed before a result is declared
  localparam logic [2:0] MATCH_NEED = 3'h5;

  // sequencing states
  typedef enum logic [2:0] {
    LFD_ARM  = 3'b001,
    LFD_RUN  = 3'b010,
    LFD_EVAL = 3'b100
  } lfd_state_t;

endpackage

// ### hw/lfd_discriminator.sv
/*
  line frequency discriminator: times rising edge to rising edge of the squared
  mains input, classifies each period as 50 Hz, 60 Hz or abnormal, and declares
  a result after five equal classifications in a row.
  assumes line_input_pin_i is asynchronous and a single 100 MHz core clock.
*/
`timescale 1ns/1ns
module lfd_discriminator #(
  parameter int unsigned TICK_CYC = lfd_pkg::TICK_CYC  // core cycles per interval tick
) (
  input  wire  logic                      core_clk_i,       // core clock, 100 MHz
  input  wire  logic                      rst_i,            // async reset, active high
  input  wire  logic                      line_input_pin_i, // squared mains waveform
  output logic                            edge_o,           // pulse: rising edge taken
  output logic [lfd_pkg::CNT_W-1:0]       period_o,         // last captured count
  output logic [1:0]                      class_o,          // last classification
  output logic                            class_stb_o,      // pulse: class_o updated
  output logic [2:0]                      match_o,          // equal classifications in a row
  output logic [1:0]                      result_o,         // declared result code
  output logic                            locked_o          // result_o is declared
);
  import lfd_pkg::*;

  localparam int unsigned PRE_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

  typedef struct packed {
    lfd_state_t       st;
    logic [2:0]       sync;
    logic             lvl;
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic             edge_p;
    logic [CNT_W-1:0] period;
    logic [1:0]       cls;
    logic             cls_stb;
    logic [2:0]       match;
    logic [1:0]       result;
    logic             locked;
  } lfd_regs_t;

  localparam lfd_regs_t REGS_RST = '{
    st:      LFD_ARM,
    sync:    3'h0,
    lvl:     1'b0,
    pre:     '0,
    cnt:     16'h0000,
    edge_p:  1'b0,
    period:  16'h0000,
    cls:     RESULT_ERROR_CODE,
    cls_stb: 1'b0,
    match:   3'h0,
    result:  RESULT_ERROR_CODE,
    locked:  1'b0
  };

  lfd_regs_t r;
  lfd_regs_t next_r;
  logic      agree;
  logic      rise;
  logic      tick;
  logic [1:0] next_cls;

  // period classification against the boundaries
  always_comb begin
    if (r.period > THR_55 && r.period <= THR_45) begin
      next_cls = RESULT_FIFTY_CODE;
    end else if (r.period > THR_65 && r.period <= THR_55) begin
      next_cls = RESULT_SIXTY_CODE;
    end else begin
      next_cls = RESULT_ERROR_CODE;
    end
  end

  // edge qualification and tick generation
  always_comb begin
    agree = (r.sync[1] == r.sync[2]);
    rise  = agree && r.sync[2] && !r.lvl;
    tick  = (r.pre == PRE_LAST);
  end

  // next-state logic
  always_comb begin
    next_r         = r;
    next_r.sync    = {r.sync[1:0], line_input_pin_i};
    next_r.edge_p  = 1'b0;
    next_r.cls_stb = 1'b0;
    if (agree) begin
      next_r.lvl = r.sync[2];
    end
    // free-running interval counter, saturates on very long periods
    if (tick) begin
      next_r.pre = '0;
      if (r.cnt != CNT_MAX) begin
        next_r.cnt = r.cnt + 16'h0001;
      end
    end else begin
      next_r.pre = r.pre + PRE_W'(1);
    end
    unique case (r.st)
      LFD_ARM: begin
        // first edge only opens the first interval
        if (rise) begin
          next_r.pre = '0;
          next_r.cnt = 16'h0000;
          next_r.st  = LFD_RUN;
        end
      end
      LFD_RUN: begin
        if (rise) begin
          next_r.period = r.cnt;
          next_r.pre    = '0;
          next_r.cnt    = 16'h0000;
          next_r.edge_p = 1'b1;
          next_r.st     = LFD_EVAL;
        end
      end
      LFD_EVAL: begin
        next_r.cls     = next_cls;
        next_r.cls_stb = 1'b1;
        next_r.st      = LFD_RUN;
        if (next_cls == RESULT_ERROR_CODE) begin
          // abnormal period: drop any result and start over
          next_r.match  = 3'h0;
          next_r.locked = 1'b0;
          next_r.result = RESULT_ERROR_CODE;
        end else if (r.match == 3'h0 || next_cls != r.cls) begin
          next_r.match  = 3'h1;
          next_r.locked = 1'b0;
          next_r.result = RESULT_ERROR_CODE;
        end else if (r.match < MATCH_NEED) begin
          next_r.match = r.match + 3'h1;
          if (r.match + 3'h1 == MATCH_NEED) begin
            next_r.locked = 1'b1;
            next_r.result = next_cls;
          end
        end
        // a rise here is at least one period away, so none is missed
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign edge_o      = r.edge_p;
  assign period_o    = r.period;
  assign class_o     = r.cls;
  assign class_stb_o = r.cls_stb;
  assign match_o     = r.match;
  assign result_o    = r.result;
  assign locked_o    = r.locked;

endmodule

// ### sim/lfd_line_src.sv
/*
  square-wave mains source for the discriminator bench.
  assumes the next period length is set well before each rising edge.
*/
`timescale 1ns/1ns
module lfd_line_src (
  input  wire logic        core_clk_i, // core clock
  input  wire logic        rst_i,      // async reset
  input  wire logic [15:0] period_i,   // next period, cycles
  output logic             line_o      // squared mains level
);
  logic [15:0] cnt;
  logic [15:0] cur;
  // high for the first half; the next length is taken at each rise
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // low in reset; the first edge wraps at once and takes the first length
      cnt <= 16'h0;
      cur <= 16'h0001;
    end else if (cnt >= cur - 16'h1) begin
      cnt <= 16'h0;
      cur <= period_i;
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
  assign line_o = (cnt < (cur >> 1));
endmodule

// ### sim/lfd_disc_sva.sv
/*
  port checker for the discriminator.
  assumes it is bound to every lfd_discriminator instance.
*/
`timescale 1ns/1ns
module lfd_disc_sva import lfd_pkg::*; #(
  parameter int unsigned TICK_CYC = 128 // cycles per tick
) (
  input wire logic        core_clk_i,  // clock
  input wire logic        rst_i,       // reset
  input wire logic        edge_o,      // edge pulse
  input wire logic [15:0] period_o,    // count
  input wire logic [1:0]  class_o,     // class
  input wire logic        class_stb_o, // class pulse
  input wire logic [2:0]  match_o,     // run length
  input wire logic [1:0]  result_o,    // result
  input wire logic        locked_o     // declared
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    edge_o ##1 class_stb_o;
  endsequence
  a_edge_to_stb: assert property (edge_o |-> s_take) else $error("no class pulse");
  a_stb_has_edge: assert property (class_stb_o |-> $past(edge_o)) else $error("stray class pulse");
  a_period_held: assert property (!edge_o |-> $stable(period_o)) else $error("count moved");
  a_fifty_range: assert property (class_stb_o && class_o == RESULT_FIFTY_CODE |->
    period_o > THR_55 && period_o <= THR_45) else $error("bad 50 class");
  a_sixty_range: assert property (class_stb_o && class_o == RESULT_SIXTY_CODE |->
    period_o > THR_65 && period_o <= THR_55) else $error("bad 60 class");
  a_abn_range: assert property (class_stb_o && class_o == 2'h0 |->
    !(period_o > THR_65 && period_o <= THR_45)) else $error("bad abnormal");
  a_lock_five: assert property (locked_o |-> match_o == MATCH_NEED) else $error("early lock");
  a_abn_clears: assert property (class_stb_o && class_o == 2'h0 |->
    match_o == 3'h0 && !locked_o && result_o == 2'h0) else $error("no restart");
  a_lock_code: assert property (locked_o |-> result_o == class_o) else $error("bad code");
endmodule
bind lfd_discriminator lfd_disc_sva #(.TICK_CYC(TICK_CYC)) i_lfd_disc_sva (.*);

// ### sim/testbench.sv
/*
  bench: mains source feeds the discriminator; a model checks each result.
  assumes a tick of one core cycle to keep the run short.
*/
`timescale 1ns/1ns
module testbench;
  import lfd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic line;
  logic [15:0] period = 16'h0;
  logic edge_p, stb, lk;
  logic [15:0] per;
  logic [1:0] cl, rs;
  logic [2:0] mt;
  int fail_count = 0;
  int checks = 0;
  int pl[9];
  int c, pc, m, n;
  // clock, 100 MHz
  always #5 core_clk = ~core_clk;
  lfd_line_src i_lfd_line_src (.core_clk_i(core_clk), .rst_i(rst), .period_i(period), .line_o(line));
  lfd_discriminator #(.TICK_CYC(1)) i_lfd_discriminator (.core_clk_i(core_clk), .rst_i(rst),
    .line_input_pin_i(line), .edge_o(edge_p), .period_o(per), .class_o(cl), .class_stb_o(stb),
    .match_o(mt), .result_o(rs), .locked_o(lk));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // five random 60 Hz periods, then boundaries and faults; a count is cycles minus one
  initial begin
    void'($urandom(32'hE1E9));
    for (int i = 0; i < 5; i++) pl[i] = 12020 + $urandom % 200;
    pl[5] = 14205;
    pl[6] = 12019;
    pl[7] = 17361;
    pl[8] = 300;
    pc = 0;
    m = 0;
    period = 16'(pl[0]);
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      period <= 16'(pl[i < 8 ? i + 1 : 8]);
      for (n = 0; n < 20000 && stb !== 1'b1; n++) @(negedge core_clk);
      if (n == 20000) begin
        fail_count++;
        close_out();
      end
      c = (pl[i] - 1 > 14204 && pl[i] - 1 <= 17360) ? 1 : (pl[i] - 1 > 12018 && pl[i] - 1 <= 14204) ? 2 : 0;
      if (c == 0) m = 0;
      else if (c == pc && m > 0) m = (m < 5) ? m + 1 : 5;
      else m = 1;
      pc = c;
      chk(per, 16'(pl[i] - 1));
      chk(16'(cl), 16'(c));
      chk(16'(mt), 16'(m));
      chk(16'(lk), 16'(m == 5));
      chk(16'(rs), 16'(m == 5 ? c : 0));
      $display("test %0d period %0d done", i, pl[i]);
      @(posedge core_clk);
    end
    close_out();
  end
endmodule
